// ===== hdl/dri_pkg.sv
// Package: constants and types for the DRAM reset and initialization sequencer
package dri_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 10000;
    localparam int unsigned CNT_W           = 32;
    // Times as printed, in picoseconds
    localparam longint unsigned T_CKE_RST_PS  = 64'd10000;
    localparam longint unsigned T_RST_WAIT_PS = 64'd500000000;
    localparam longint unsigned T_CLK_STB_PS  = 64'd10000;
    localparam longint unsigned T_IDLE_PS     = 64'd960000000000;
    // Least times round up
    localparam int unsigned CYC_CKE_RST  = 32'((T_CKE_RST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int unsigned CYC_RST_WAIT = 32'((T_RST_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int unsigned CYC_CLK_STB0 = 32'((T_CLK_STB_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int unsigned CLK_STB_MIN_TCK = 5;
    localparam int unsigned CYC_CLK_STB  = (CYC_CLK_STB0 > CLK_STB_MIN_TCK) ? CYC_CLK_STB0
                                                                          : CLK_STB_MIN_TCK;
    // Longest time rounds down
    localparam int unsigned CYC_IDLE     = 32'(T_IDLE_PS / CLK_PERIOD_PS);
    localparam int unsigned XPR_MIN_TCK  = 5;
    // Default wait counts in clock cycles
    localparam int unsigned DEF_PW_RESET = 20;
    localparam int unsigned DEF_XS       = 30;
    localparam int unsigned DEF_MRD      = 8;
    localparam int unsigned DEF_MOD      = 24;
    localparam int unsigned DEF_DLLK     = 1024;
    localparam int unsigned DEF_ZQINIT   = 1024;
    localparam int unsigned DEF_REFI     = 780;
    // Mode register selects (BG0,BA1,BA0)
    localparam logic [2:0] MR_SEL_0 = 3'h0;
    localparam logic [2:0] MR_SEL_1 = 3'h1;
    localparam logic [2:0] MR_SEL_2 = 3'h2;
    localparam logic [2:0] MR_SEL_3 = 3'h3;
    localparam logic [2:0] MR_SEL_4 = 3'h4;
    localparam logic [2:0] MR_SEL_5 = 3'h5;
    localparam logic [2:0] MR_SEL_6 = 3'h6;
    localparam int unsigned MR_COUNT = 7;
    localparam int unsigned MR_W     = 18;
    // Command encoding {cs_n, act_n, ras_n, cas_n, we_n}
    typedef enum logic [4:0] {
        DRI_CMD_DES = 5'h1F,
        DRI_CMD_MRS = 5'h10,
        DRI_CMD_REF = 5'h11,
        DRI_CMD_ZQC = 5'h16
    } dri_cmd_e;
endpackage : dri_pkg

// ===== hdl/dri_wait_if.sv
// Interface: wait counter load and expiry between sequencer and timer
`timescale 1ns/100ps
interface dri_wait_if;
    logic                         load;
    logic [dri_pkg::CNT_W-1:0]    cycles;
    logic                         done;
    modport ctl (output load, output cycles, input done);
    modport tmr (input load, input cycles, output done);
endinterface : dri_wait_if

// ===== hdl/dri_wait_timer.sv
// Wait timer: counts a loaded number of cycles and flags expiry
`timescale 1ns/100ps
module dri_wait_timer (
    input  wire logic  sys_clk,
    input  wire logic  rst,
    dri_wait_if.tmr    wt
);
    import dri_pkg::*;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             done_q;
    logic             next_done_q;

    always_comb begin
        next_count  = count;
        next_done_q = 1'b0;
        if (wt.load) begin
            next_count = (wt.cycles > 1) ? wt.cycles - CNT_W'(1) : '0;
            next_done_q = (wt.cycles <= 1);
        end else if (count != '0) begin
            next_count = count - CNT_W'(1);
            next_done_q = (count == CNT_W'(1));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Preloaded so the CKE lead wait after reset ends without a load
            count  <= CNT_W'(CYC_CKE_RST);
            done_q <= 1'b0;
        end else begin
            count  <= next_count;
            done_q <= next_done_q;
        end
    end
    assign wt.done = done_q;
endmodule : dri_wait_timer

// ===== hdl/dri_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module dri_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule : dri_sync

// ===== hdl/dri_init_ctrl.sv
// Host-side DRAM reset, initialization and idle keep-alive sequencer
`timescale 1ns/100ps
module dri_init_ctrl #(
    parameter int unsigned PW_RESET_CYC = dri_pkg::DEF_PW_RESET,
    parameter int unsigned RST_WAIT_CYC = dri_pkg::CYC_RST_WAIT,
    parameter int unsigned XS_CYC       = dri_pkg::DEF_XS,
    parameter int unsigned MRD_CYC      = dri_pkg::DEF_MRD,
    parameter int unsigned MOD_CYC      = dri_pkg::DEF_MOD,
    parameter int unsigned DLLK_CYC     = dri_pkg::DEF_DLLK,
    parameter int unsigned ZQINIT_CYC   = dri_pkg::DEF_ZQINIT,
    parameter int unsigned REFI_CYC     = dri_pkg::DEF_REFI,
    parameter int unsigned IDLE_CYC     = dri_pkg::CYC_IDLE
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      warm_reset_req,
    input  wire logic                      recal_req,
    input  wire logic                      rtt_nom_en,
    input  wire logic                      odt_level,
    input  wire logic [dri_pkg::MR_W-1:0]  mr0_val,
    input  wire logic [dri_pkg::MR_W-1:0]  mr1_val,
    input  wire logic [dri_pkg::MR_W-1:0]  mr2_val,
    input  wire logic [dri_pkg::MR_W-1:0]  mr3_val,
    input  wire logic [dri_pkg::MR_W-1:0]  mr4_val,
    input  wire logic [dri_pkg::MR_W-1:0]  mr5_val,
    input  wire logic [dri_pkg::MR_W-1:0]  mr6_val,
    output logic                           reset_n,
    output logic                           cke,
    output logic                           ck_en,
    output logic                           cs_n,
    output logic                           act_n,
    output logic                           ras_n,
    output logic                           cas_n,
    output logic                           we_n,
    output logic [2:0]                     ba_bg,
    output logic [dri_pkg::MR_W-1:0]       addr,
    output logic                           odt,
    output logic                           ten,
    output logic                           init_done
);
    import dri_pkg::*;

    typedef enum logic [3:0] {
        ST_RST_HOLD, ST_CKE_LOW, ST_POST_RST, ST_CLK_STB, ST_XPR,
        ST_MRS, ST_MRD, ST_MOD, ST_ZQCL, ST_DLLK, ST_IDLE
    } dri_state_e;

    dri_state_e       state;
    dri_state_e       next_state;
    logic [2:0]       mr_idx;
    logic [2:0]       next_mr_idx;
    logic             next_reset_n;
    logic             next_cke;
    logic             next_ck_en;
    logic [4:0]       cmd;
    logic [4:0]       next_cmd;
    logic [2:0]       next_ba_bg;
    logic [MR_W-1:0]  next_addr;
    logic             odt_q;
    logic             next_odt;
    logic             next_init_done;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] next_idle_cnt;
    logic             warm_s;
    logic             recal_s;
    logic             warm_d;
    logic             recal_d;
    logic             next_warm_d;
    logic             next_recal_d;
    dri_wait_if       wt ();

    dri_sync #(.W(2)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({warm_reset_req, recal_req}),
        .q       ({warm_s, recal_s})
    );

    dri_wait_timer u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wt      (wt)
    );

    // Write order MR3, MR6, MR5, MR4, MR2, MR1, MR0; MR1 ahead of MR0 keeps DLL enable first
    function automatic logic [2:0] mr_sel(input logic [2:0] idx);
        case (idx)
            3'h0:    mr_sel = MR_SEL_3;
            3'h1:    mr_sel = MR_SEL_6;
            3'h2:    mr_sel = MR_SEL_5;
            3'h3:    mr_sel = MR_SEL_4;
            3'h4:    mr_sel = MR_SEL_2;
            3'h5:    mr_sel = MR_SEL_1;
            default: mr_sel = MR_SEL_0;
        endcase
    endfunction : mr_sel

    function automatic logic [MR_W-1:0] mr_data(input logic [2:0] sel);
        case (sel)
            MR_SEL_0: mr_data = mr0_val;
            MR_SEL_1: mr_data = mr1_val;
            MR_SEL_2: mr_data = mr2_val;
            MR_SEL_3: mr_data = mr3_val;
            MR_SEL_4: mr_data = mr4_val;
            MR_SEL_5: mr_data = mr5_val;
            default:  mr_data = mr6_val;
        endcase
    endfunction : mr_data

    function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
        cyc = CNT_W'(n);
    endfunction : cyc

    always_comb begin
        next_state     = state;
        next_mr_idx    = mr_idx;
        next_reset_n   = reset_n;
        next_cke       = cke;
        next_ck_en     = ck_en;
        next_cmd       = DRI_CMD_DES;
        next_ba_bg     = 3'h0;
        next_addr      = '0;
        next_odt       = odt_q;
        next_init_done = init_done;
        next_idle_cnt  = idle_cnt;
        next_warm_d    = warm_s;
        next_recal_d   = recal_s;
        wt.load        = 1'b0;
        wt.cycles      = '0;
        case (state)
            ST_RST_HOLD: begin
                // Hold RESET_n for tPW_RESET with CKE low
                next_reset_n = 1'b0;
                next_cke     = 1'b0;
                if (wt.done) begin
                    next_state = ST_CKE_LOW;
                    wt.load    = 1'b1;
                    wt.cycles  = cyc(CYC_CKE_RST);
                end
            end
            ST_CKE_LOW: begin
                if (wt.done) begin
                    next_reset_n = 1'b1;
                    next_state   = ST_POST_RST;
                    wt.load      = 1'b1;
                    wt.cycles    = cyc(RST_WAIT_CYC);
                end
            end
            ST_POST_RST: begin
                // Device self-initializes here; clock is started late so it does not matter
                if (wt.done) begin
                    next_ck_en = 1'b1;
                    next_state = ST_CLK_STB;
                    wt.load    = 1'b1;
                    wt.cycles  = cyc(CYC_CLK_STB);
                end
            end
            ST_CLK_STB: begin
                if (wt.done) begin
                    next_cke   = 1'b1;
                    next_odt   = rtt_nom_en ? 1'b0 : odt_level;
                    next_state = ST_XPR;
                    next_mr_idx = 3'h0;
                    wt.load    = 1'b1;
                    wt.cycles  = cyc((XS_CYC > XPR_MIN_TCK) ? XS_CYC : XPR_MIN_TCK);
                end
            end
            ST_XPR: begin
                if (wt.done) begin
                    next_state = ST_MRS;
                end
            end
            ST_MRS: begin
                // Full register image every time; nothing relies on power-up defaults
                next_cmd   = DRI_CMD_MRS;
                next_ba_bg = mr_sel(mr_idx);
                next_addr  = mr_data(mr_sel(mr_idx));
                wt.load    = 1'b1;
                if (mr_idx == 3'(MR_COUNT - 1)) begin
                    next_state = ST_MOD;
                    wt.cycles  = cyc(MOD_CYC);
                end else begin
                    next_state = ST_MRD;
                    wt.cycles  = cyc(MRD_CYC);
                end
            end
            ST_MRD: begin
                if (wt.done) begin
                    next_mr_idx = mr_idx + 3'h1;
                    next_state  = ST_MRS;
                end
            end
            ST_MOD: begin
                if (wt.done) begin
                    next_state = ST_ZQCL;
                end
            end
            ST_ZQCL: begin
                next_cmd   = DRI_CMD_ZQC;
                next_addr  = MR_W'(18'h00400);
                next_state = ST_DLLK;
                wt.load    = 1'b1;
                wt.cycles  = cyc((DLLK_CYC > ZQINIT_CYC) ? DLLK_CYC : ZQINIT_CYC);
            end
            ST_DLLK: begin
                if (wt.done) begin
                    next_init_done = 1'b1;
                    next_idle_cnt  = '0;
                    next_state     = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Periodic refresh keeps the idle device alive well inside 960ms
                next_idle_cnt = idle_cnt + CNT_W'(1);
                if (idle_cnt >= cyc((REFI_CYC < IDLE_CYC) ? REFI_CYC : IDLE_CYC) - 1) begin
                    next_cmd      = DRI_CMD_REF;
                    next_idle_cnt = '0;
                end
                if (recal_s && !recal_d) begin
                    // Rerun MRS (MR0 with DLL reset) and ZQCL after supply change
                    next_init_done = 1'b0;
                    next_mr_idx    = 3'h0;
                    next_cmd       = DRI_CMD_DES;
                    next_state     = ST_MRS;
                end
            end
            default: next_state = ST_RST_HOLD;
        endcase
        if (warm_s && !warm_d) begin
            // Warm reset may start anywhere; drops CKE and RESET_n in the same cycle, timer restarts
            next_state     = ST_RST_HOLD;
            next_reset_n   = 1'b0;
            next_cke       = 1'b0;
            next_init_done = 1'b0;
            next_cmd       = DRI_CMD_DES;
            next_ba_bg     = 3'h0;
            next_addr      = '0;
            next_odt       = 1'b0;
            wt.load        = 1'b1;
            wt.cycles      = cyc(PW_RESET_CYC);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state     <= ST_CKE_LOW;
            mr_idx    <= 3'h0;
            reset_n   <= 1'b0;
            cke       <= 1'b0;
            ck_en     <= 1'b0;
            cmd       <= DRI_CMD_DES;
            ba_bg     <= 3'h0;
            addr      <= '0;
            odt_q     <= 1'b0;
            init_done <= 1'b0;
            idle_cnt  <= '0;
            warm_d    <= 1'b0;
            recal_d   <= 1'b0;
            ten       <= 1'b0;
        end else begin
            state     <= next_state;
            mr_idx    <= next_mr_idx;
            reset_n   <= next_reset_n;
            cke       <= next_cke;
            ck_en     <= next_ck_en;
            cmd       <= next_cmd;
            ba_bg     <= next_ba_bg;
            addr      <= next_addr;
            odt_q     <= next_odt;
            init_done <= next_init_done;
            idle_cnt  <= next_idle_cnt;
            warm_d    <= next_warm_d;
            recal_d   <= next_recal_d;
            ten       <= 1'b0;
        end
    end

    assign cs_n  = cmd[4];
    assign act_n = cmd[3];
    assign ras_n = cmd[2];
    assign cas_n = cmd[1];
    assign we_n  = cmd[0];
    assign odt   = odt_q;
endmodule : dri_init_ctrl

// ===== verif/dri_init_ctrl_props.sv
// Checker: pin timing and command order of the init sequencer
`timescale 1ns/100ps
module dri_init_ctrl_props
    import dri_pkg::*;
#(
    parameter int unsigned PW_RESET_CYC = 20,
    parameter int unsigned RST_WAIT_CYC = 200,
    parameter int unsigned XS_CYC       = 30,
    parameter int unsigned MRD_CYC      = 8,
    parameter int unsigned MOD_CYC      = 24,
    parameter int unsigned DLLK_CYC     = 64,
    parameter int unsigned ZQINIT_CYC   = 32,
    parameter int unsigned REFI_CYC     = 100
) (
    input wire logic                      sys_clk,
    input wire logic                      rst,
    input wire logic                      rtt_nom_en,
    input wire logic                      reset_n,
    input wire logic                      cke,
    input wire logic                      ck_en,
    input wire logic                      cs_n,
    input wire logic                      act_n,
    input wire logic                      ras_n,
    input wire logic                      cas_n,
    input wire logic                      we_n,
    input wire logic [2:0]                ba_bg,
    input wire logic [dri_pkg::MR_W-1:0]  addr,
    input wire logic                      odt,
    input wire logic                      ten,
    input wire logic                      init_done
);
    localparam int unsigned XPR = (XS_CYC > XPR_MIN_TCK) ? XS_CYC : XPR_MIN_TCK;
    localparam int unsigned DLW = (DLLK_CYC > ZQINIT_CYC) ? DLLK_CYC : ZQINIT_CYC;
    localparam logic [2:0] ORD [0:6] = '{MR_SEL_3, MR_SEL_6, MR_SEL_5, MR_SEL_4,
                                        MR_SEL_2, MR_SEL_1, MR_SEL_0};
    logic [4:0]  cmd;
    logic [31:0] rw_cnt, ck_cnt, gap, ref_gap, lo_cnt;
    logic [2:0]  mr_idx;
    logic        warm, prev_rn;
    assign cmd = {cs_n, act_n, ras_n, cas_n, we_n};
    // Gap starts high so a first MRS passes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rw_cnt  <= '0;
            ck_cnt  <= '0;
            gap     <= 32'h0000FFFF;
            ref_gap <= '0;
            lo_cnt  <= '0;
            mr_idx  <= 3'h0;
            warm    <= 1'b0;
            prev_rn <= 1'b0;
        end else begin
            rw_cnt  <= reset_n ? rw_cnt + 32'h1 : '0;
            ck_cnt  <= cke ? ck_cnt + 32'h1 : '0;
            gap     <= (cmd != DRI_CMD_DES) ? '0 : gap + 32'h1;
            ref_gap <= (!init_done || cmd != DRI_CMD_DES) ? '0 : ref_gap + 32'h1;
            lo_cnt  <= reset_n ? '0 : lo_cnt + 32'h1;
            mr_idx  <= (!cke || cmd == DRI_CMD_ZQC) ? 3'h0 :
                       (cmd == DRI_CMD_MRS) ? mr_idx + 3'h1 : mr_idx;
            warm    <= warm | (prev_rn & ~reset_n);
            prev_rn <= reset_n;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_ten_low: assert property (ten == 1'b0)
        else $error("ten driven high");
    chk_cke_lead: assert property ($rose(reset_n) |-> !cke && !$past(cke))
        else $error("cke high at release");
    chk_rst_wait: assert property ($rose(cke) |-> rw_cnt >= RST_WAIT_CYC)
        else $error("cke too soon");
    chk_clk_stable: assert property ($rose(cke) |-> $past(ck_en, 5) && ck_en)
        else $error("clock late");
    chk_des_cke: assert property ($rose(cke) |-> cmd == DRI_CMD_DES)
        else $error("no deselect at cke");
    chk_cke_held: assert property ($fell(cke) |-> !reset_n)
        else $error("cke dropped");
    chk_odt_static: assert property (cke && $past(cke) && !init_done |-> $stable(odt))
        else $error("odt moved during init");
    chk_odt_rtt: assert property (cke && rtt_nom_en && !init_done |-> !odt)
        else $error("odt high with rtt");
    chk_xpr_wait: assert property (cmd == DRI_CMD_MRS |-> ck_cnt >= XPR)
        else $error("mrs before xpr");
    chk_mrd_gap: assert property (cmd == DRI_CMD_MRS && mr_idx != 3'h0
        |-> gap >= MRD_CYC - 1)
        else $error("mode writes too close");
    chk_mr_order: assert property (cmd == DRI_CMD_MRS |-> ba_bg == ORD[mr_idx])
        else $error("mrs order");
    chk_zq_after_mod: assert property (cmd == DRI_CMD_ZQC
        |-> gap >= MOD_CYC - 1 && mr_idx == 3'h7 && addr == 18'h00400)
        else $error("zqcl wrong");
    chk_init_wait: assert property ($rose(init_done) |-> gap >= DLW - 1)
        else $error("init done early");
    chk_init_cmds: assert property (cke && !init_done
        |-> cmd inside {DRI_CMD_DES, DRI_CMD_MRS, DRI_CMD_ZQC})
        else $error("bad init command");
    chk_refresh: assert property (init_done |-> ref_gap <= REFI_CYC + 2)
        else $error("refresh late");
    chk_pw_hold: assert property ($rose(reset_n) && warm |-> lo_cnt >= PW_RESET_CYC)
        else $error("reset pulse short");
endmodule : dri_init_ctrl_props
bind dri_init_ctrl dri_init_ctrl_props #(
    .PW_RESET_CYC(PW_RESET_CYC), .RST_WAIT_CYC(RST_WAIT_CYC), .XS_CYC(XS_CYC),
    .MRD_CYC(MRD_CYC), .MOD_CYC(MOD_CYC), .DLLK_CYC(DLLK_CYC),
    .ZQINIT_CYC(ZQINIT_CYC), .REFI_CYC(REFI_CYC)
) dri_init_ctrl_props_i (
    .sys_clk(sys_clk), .rst(rst), .rtt_nom_en(rtt_nom_en), .reset_n(reset_n),
    .cke(cke), .ck_en(ck_en), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba_bg(ba_bg), .addr(addr), .odt(odt), .ten(ten),
    .init_done(init_done)
);

// ===== verif/dri_dram_model.sv
// Behavioural memory device seen by the init sequencer
`timescale 1ns/100ps
module dri_dram_model (
    input  wire logic                                        sys_clk,
    input  wire logic                                        reset_n,
    input  wire logic                                        cke,
    input  wire logic [4:0]                                  cmd,
    input  wire logic [2:0]                                  ba_bg,
    input  wire logic [dri_pkg::MR_W-1:0]                    addr,
    input  wire logic                                        odt,
    output logic [dri_pkg::MR_COUNT-1:0][dri_pkg::MR_W-1:0]  mr_img,
    output logic [dri_pkg::MR_COUNT-1:0]                     mr_set,
    output logic [15:0]                                      mrs_cnt,
    output logic [15:0]                                      ref_cnt,
    output logic                                             zq_done,
    output logic                                             term_on,
    output logic                                             self_init
);
    import dri_pkg::*;
    logic cke_seen;
    // Termination off until cke registered high
    assign term_on = cke_seen & odt & reset_n;
    // Init needs no clock, only the release
    always @(posedge reset_n) self_init <= #1000 1'b1;
    always @(negedge reset_n) self_init <= 1'b0;
    initial ref_cnt = '0;
    initial self_init = 1'b0;
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            // Reset keeps the refresh count and the register images
            cke_seen <= 1'b0;
            mr_set   <= '0;
            mrs_cnt  <= '0;
            zq_done  <= 1'b0;
        end else if (cke) begin
            cke_seen <= 1'b1;
            if (cmd == DRI_CMD_MRS && ba_bg < 3'h7) begin
                mr_img[ba_bg] <= addr;
                mr_set[ba_bg] <= 1'b1;
                mrs_cnt       <= mrs_cnt + 16'h1;
            end
            if (cmd == DRI_CMD_ZQC)
                zq_done <= 1'b1;
            if (cmd == DRI_CMD_REF)
                ref_cnt <= ref_cnt + 16'h1;
        end
    end
endmodule : dri_dram_model

// ===== verif/dri_init_ctrl_test.sv
// Testbench: power-on, idle refresh, warm reset and recalibration
`timescale 1ns/100ps
module dri_init_ctrl_test;
    import dri_pkg::*;
    localparam int unsigned PW = 20, RW = 200, REFI = 100;
    logic                           sys_clk, rst, warm_reset_req, recal_req, rtt_nom_en;
    logic                           odt_level, reset_n, cke, ck_en, cs_n, act_n, ras_n;
    logic                           cas_n, we_n, odt, ten, init_done, zq_done, term_on;
    logic                           self_init;
    logic [2:0]                     ba_bg;
    logic [MR_W-1:0]                addr;
    logic [MR_W-1:0]                mr_v [MR_COUNT];
    logic [MR_COUNT-1:0][MR_W-1:0]  mr_img;
    logic [MR_COUNT-1:0]            mr_set;
    logic [15:0]                    mrs_cnt, ref_cnt;
    int                             errors = 0;
    int                             n_checks = 0;

    dri_init_ctrl #(.PW_RESET_CYC(PW), .RST_WAIT_CYC(RW), .DLLK_CYC(64), .ZQINIT_CYC(32),
        .REFI_CYC(REFI)) dri_init_ctrl_i (
        .sys_clk(sys_clk), .rst(rst), .warm_reset_req(warm_reset_req),
        .recal_req(recal_req), .rtt_nom_en(rtt_nom_en), .odt_level(odt_level),
        .mr0_val(mr_v[0]), .mr1_val(mr_v[1]), .mr2_val(mr_v[2]), .mr3_val(mr_v[3]),
        .mr4_val(mr_v[4]), .mr5_val(mr_v[5]), .mr6_val(mr_v[6]), .reset_n(reset_n),
        .cke(cke), .ck_en(ck_en), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba_bg(ba_bg), .addr(addr), .odt(odt), .ten(ten),
        .init_done(init_done));
    dri_dram_model dri_dram_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .cke(cke),
        .cmd({cs_n, act_n, ras_n, cas_n, we_n}), .ba_bg(ba_bg), .addr(addr), .odt(odt),
        .mr_img(mr_img), .mr_set(mr_set), .mrs_cnt(mrs_cnt), .ref_cnt(ref_cnt),
        .zq_done(zq_done), .term_on(term_on), .self_init(self_init));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // Released-reset cycles until cke rises
    task automatic count_to_cke(output int n);
        n = 0;
        while (cke !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            if (reset_n === 1'b1)
                n++;
        end
    endtask : count_to_cke

    task automatic wait_done();
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_done

    // Model images must match the programmed values
    task automatic check_regs(input logic odt_exp);
        check(32'(init_done), 32'h1, "init done");
        check(32'(zq_done), 32'h1, "zq");
        check(32'(mr_set), 32'h7F, "mr set");
        check(32'(mrs_cnt), 32'h7, "mrs count");
        for (int i = 0; i < MR_COUNT; i++)
            check(32'(mr_img[i]), 32'(mr_v[i]), "mr image");
        check(32'(odt), 32'(odt_exp), "odt");
        check(32'(term_on), 32'(odt_exp), "termination");
        check(32'(ten), 32'h0, "ten");
    endtask : check_regs

    task automatic test_power_on();
        int n;
        count_to_cke(n);
        check(32'(n >= RW && n < 2 * RW), 32'h1, "release to cke");
        wait_done();
        check_regs(1'b0);
        $display("test_power_on done");
    endtask : test_power_on

    task automatic test_idle_refresh();
        logic [15:0] r0;
        r0 = ref_cnt;
        repeat (REFI * 5) @(posedge sys_clk);
        check(32'(ref_cnt - r0 >= 16'h4), 32'h1, "refreshes");
        check(32'(cke), 32'h1, "cke high");
        $display("test_idle_refresh done");
    endtask : test_idle_refresh

    task automatic test_warm_reset();
        int          n;
        logic [15:0] r0;
        @(posedge sys_clk);
        for (int i = 0; i < MR_COUNT; i++)
            mr_v[i] <= mr_v[i] ^ 18'h0F0F0;
        rtt_nom_en     <= 1'b0;
        warm_reset_req <= 1'b1;
        n = 0;
        while (reset_n !== 1'b0 && n < 10) begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(reset_n), 32'h0, "warm taken");
        r0 = ref_cnt;
        warm_reset_req <= 1'b0;
        recal_req      <= 1'b1;
        n = 0;
        while (reset_n !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(n >= PW), 32'h1, "pulse width");
        check(32'(cke), 32'h0, "cke low");
        recal_req <= 1'b0;
        count_to_cke(n);
        odt_level <= 1'b0;
        check(32'(n >= RW && n < 2 * RW), 32'h1, "warm to cke");
        wait_done();
        check(32'(ref_cnt), 32'(r0), "ref kept");
        check(32'(self_init), 32'h1, "self init");
        check_regs(1'b1);
        $display("test_warm_reset done");
    endtask : test_warm_reset

    task automatic test_recal();
        logic [15:0] m0;
        m0 = mrs_cnt;
        @(posedge sys_clk);
        recal_req <= 1'b1;
        repeat (300) @(posedge sys_clk);
        recal_req <= 1'b0;
        check(32'(mrs_cnt - m0), 32'h7, "rewrites");
        check(32'(init_done), 32'h1, "recal done");
        $display("test_recal done");
    endtask : test_recal

    initial begin
        rst            = 1'b1;
        warm_reset_req = 1'b0;
        recal_req      = 1'b0;
        rtt_nom_en     = 1'b1;
        odt_level      = 1'b1;
        // Bit 0 of MR1 and bit 8 of MR0 set: DLL enabled before its reset
        for (int i = 0; i < MR_COUNT; i++)
            mr_v[i] = MR_W'(18'h01111 * i) | 18'h00101;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        test_power_on();
        test_idle_refresh();
        test_warm_reset();
        test_recal();
        print_verdict();
    end

    // Run takes near 1600 cycles
    initial begin
        repeat (10000) @(posedge sys_clk);
        errors++;
        $display("unexpected at %0t: timeout", $time);
        print_verdict();
    end
endmodule : dri_init_ctrl_test
